//--- design/mstsel_top.v
// Memory strobe timing select: Wishbone register and four strobe shapers
//
// Overview of operation
// - Extended timing lengthens strobes by half clock
// - Bit 3 picks read strobe one timing
// - Bit 2 picks read strobe zero timing
// - Bit 1 picks write strobe one timing
// - Bit 0 picks write strobe zero timing
`include "mstsel_defines.vh"

module mstsel_top #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input  wire              i_sys_clk,
	input  wire              i_rst_b,
	// Wishbone slave
	input  wire              i_wb_cyc,
	input  wire              i_wb_stb,
	input  wire              i_wb_we,
	input  wire [ADDR_W-1:0] i_wb_adr,
	input  wire [3:0]        i_wb_sel,
	input  wire [31:0]       i_wb_dat,
	output wire [31:0]       o_wb_dat,
	output wire              o_wb_ack,
	// Sequencer requests, active high
	input  wire              i_read_req_zero,
	input  wire              i_read_req_one,
	input  wire              i_write_req_zero,
	input  wire              i_write_req_one,
	// Memory strobes, active low
	output wire              o_read_strobe_zero_b,
	output wire              o_read_strobe_one_b,
	output wire              o_write_strobe_zero_b,
	output wire              o_write_strobe_one_b
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function hit_timing;
		input [ADDR_W-1:0] adr;
		begin
			hit_timing = (adr[ADDR_W-1:2] == `MSTSEL_TIMING_IDX);
		end
	endfunction

	reg  [3:0]  timing_q;
	reg  [3:0]  timing_d;
	reg         ack_q;
	reg  [31:0] rdat_q;
	reg  [31:0] rdat_d;
	wire        req;

	assign req = i_wb_cyc & i_wb_stb & ~ack_q;

	// ----------------------------------------------------------------
	// Register write and read
	// ----------------------------------------------------------------
	always @*
	begin
		timing_d = timing_q;
		rdat_d   = 32'h00000000;
		if (req && hit_timing(i_wb_adr))
			rdat_d = {28'h0000000, timing_q};
		// Write lands at the edge where the master samples ack
		// Reserved bits dropped
		if (i_wb_cyc && i_wb_stb && ack_q && i_wb_we && i_wb_sel[0] && hit_timing(i_wb_adr))
			timing_d = i_wb_dat[3:0] & `MSTSEL_USED_MASK;
	end

	always @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			timing_q <= `MSTSEL_TIMING_RESET;
			ack_q    <= 1'b0;
			rdat_q   <= 32'h00000000;
		end
		else
		begin
			timing_q <= timing_d;
			ack_q    <= req;
			rdat_q   <= rdat_d;
		end
	end

	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;

	// ----------------------------------------------------------------
	// Strobe shapers
	// ----------------------------------------------------------------
	// A timing change during an access can shorten that one strobe;
	// software should change the bits only between memory cycles.
	// Read strobe zero select
	mstsel_shaper #(.IS_WRITE(0)) u_read_zero (
		.i_sys_clk  (i_sys_clk),
		.i_rst_b    (i_rst_b),
		.i_extend   (timing_q[`MSTSEL_BIT_READ_ZERO]),
		.i_req      (i_read_req_zero),
		.o_strobe_b (o_read_strobe_zero_b)
	);

	mstsel_shaper #(.IS_WRITE(0)) u_read_one (
		.i_sys_clk  (i_sys_clk),
		.i_rst_b    (i_rst_b),
		.i_extend   (timing_q[`MSTSEL_BIT_READ_ONE]),
		.i_req      (i_read_req_one),
		.o_strobe_b (o_read_strobe_one_b)
	);

	mstsel_shaper #(.IS_WRITE(1)) u_write_zero (
		.i_sys_clk  (i_sys_clk),
		.i_rst_b    (i_rst_b),
		.i_extend   (timing_q[`MSTSEL_BIT_WRITE_ZERO]),
		.i_req      (i_write_req_zero),
		.o_strobe_b (o_write_strobe_zero_b)
	);

	mstsel_shaper #(.IS_WRITE(1)) u_write_one (
		.i_sys_clk  (i_sys_clk),
		.i_rst_b    (i_rst_b),
		.i_extend   (timing_q[`MSTSEL_BIT_WRITE_ONE]),
		.i_req      (i_write_req_one),
		.o_strobe_b (o_write_strobe_one_b)
	);

endmodule

//--- shared/mstsel_defines.vh
// Register map, field positions and reset values of the strobe timing select block
`ifndef MSTSEL_DEFINES_VH
`define MSTSEL_DEFINES_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define MSTSEL_TIMING_IDX     6'h19
`define MSTSEL_TIMING_ADDR    8'h64

// ----------------------------------------------------------------
// Fields of memory_strobe_timing
// ----------------------------------------------------------------
`define MSTSEL_BIT_WRITE_ZERO 0
`define MSTSEL_BIT_WRITE_ONE  1
`define MSTSEL_BIT_READ_ZERO  2
`define MSTSEL_BIT_READ_ONE   3
`define MSTSEL_USED_MASK      4'hf
`define MSTSEL_TIMING_RESET   4'h0

`endif

//--- design/mstsel_shaper.v
// One memory strobe shaper with normal or extended timing on half-clock resolution
module mstsel_shaper #(
	parameter IS_WRITE = 0
) (
	// Clock and reset
	input  wire i_sys_clk,
	input  wire i_rst_b,
	// Control
	input  wire i_extend,
	input  wire i_req,
	// Strobe pin, active low
	output wire o_strobe_b
);

	// ----------------------------------------------------------------
	// Rising and falling edge stages
	// ----------------------------------------------------------------
	reg  rise_q;
	reg  fall_q;
	reg  fall2_q;
	wire active;

	always @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			rise_q <= 1'b0;
		else
			rise_q <= i_req;
	end

	// Falling-edge stages give the half-clock steps
	always @(negedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			fall_q  <= 1'b0;
			fall2_q <= 1'b0;
		end
		else
		begin
			fall_q  <= i_req;
			fall2_q <= rise_q;
		end
	end

	// ----------------------------------------------------------------
	// Strobe shape
	// ----------------------------------------------------------------
	// Terms are chosen so that each transition is caused by one flop only,
	// which keeps the pin free of glitches at the edges.
	generate
		if (IS_WRITE != 0)
		begin : g_write
			assign active = (i_extend ? fall_q : rise_q) | fall2_q;
		end
		else
		begin : g_read
			assign active = rise_q | (i_extend & fall_q & i_req);
		end
	endgenerate

	assign o_strobe_b = ~active;

endmodule

//--- test/mstsel_monitor.sv
// Checker of strobe shapes and register read-back
module mstsel_monitor (
	input wire logic        i_sys_clk, i_rst_b, i_wb_we, o_wb_ack,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [3:0]  i_wb_sel,
	input wire logic [31:0] i_wb_dat, o_wb_dat,
	input wire logic        i_read_req_zero, i_read_req_one, i_write_req_zero, i_write_req_one,
	input wire logic        o_read_strobe_zero_b, o_read_strobe_one_b,
	input wire logic        o_write_strobe_zero_b, o_write_strobe_one_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] t_q;
	wire  [3:0] r = {i_read_req_one, i_read_req_zero, i_write_req_one, i_write_req_zero};
	wire  [3:0] s = {o_read_strobe_one_b, o_read_strobe_zero_b, o_write_strobe_one_b,
		o_write_strobe_zero_b};
	// Shadow of the timing bits, taken at the acked write
	always @(posedge i_sys_clk or negedge i_rst_b)
		if (!i_rst_b)
			t_q <= 4'h0;
		else if (o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr[7:2] == 6'h19)
			t_q <= i_wb_dat[3:0];
	property p_readback;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_wb_ack && !i_wb_we && i_wb_adr[7:2] == 6'h19 |-> o_wb_dat == {28'h0, t_q};
	endproperty
	a_readback: assert property (p_readback) else $error("bad read-back");
	property p_ack_pulse;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_dat_idle;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		!o_wb_ack |-> o_wb_dat == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	for (genvar k = 0; k < 4; k++)
	begin : g_s
		sequence s_low;
			!s[k];
		endsequence
		property p_start;
			@(posedge i_sys_clk) disable iff (!i_rst_b)
			$rose(r[k]) |-> s[k] == !t_q[k] ##1 s_low;
		endproperty
		a_start: assert property (p_start) else $error("bad strobe start");
		sequence s_req_quiet;
			!r[k] ##1 !r[k] ##1 !r[k];
		endsequence
		property p_quiet;
			@(posedge i_sys_clk) disable iff (!i_rst_b)
			s_req_quiet |-> s[k];
		endproperty
		a_quiet: assert property (p_quiet) else $error("strobe low without request");
		// Writes hold half a clock longer than reads
		property p_end;
			@(negedge i_sys_clk) disable iff (!i_rst_b)
			$fell(r[k]) |-> s_low ##1 s[k] == (k > 1) ##1 s[k];
		endproperty
		a_end: assert property (p_end) else $error("bad strobe end");
	end
endmodule
bind mstsel_top mstsel_monitor i_mstsel_monitor (.*);

//--- test/mstsel_mem_model.sv
// Memory side: measures each strobe's low time in half clocks
module mstsel_mem_model (
	input  wire logic       i_sys_clk,
	input  wire logic [3:0] i_strobe_b,
	output logic [31:0]     o_len
);
	timeunit 1ns;
	timeprecision 1ps;
	event done;
	int cnt[4] = '{0, 0, 0, 0};
	always @(i_sys_clk)
	begin
		#1;
		for (int k = 0; k < 4; k++)
			if (!i_strobe_b[k])
				cnt[k]++;
			else if (cnt[k] > 0)
			begin
				o_len = cnt[k];
				cnt[k] = 0;
				-> done;
			end
	end
endmodule

//--- test/tb_memory_strobe_timing_select.sv
// Self-checking bench of the strobe timing select block
module tb_memory_strobe_timing_select;
	timeunit 1ns;
	timeprecision 1ps;
	`define CMP(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
		$display("BAD %0t %h %h", $time, a, e); end end
	logic i_sys_clk = 0, i_rst_b = 0, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
	logic [7:0]  i_wb_adr = 8'h00;
	logic [3:0]  i_wb_sel = 4'h0, r = 4'h0, t = 4'h0;
	logic [31:0] i_wb_dat = 32'h0, len, ea, eb;
	logic [31:0] q[$];
	wire  [31:0] o_wb_dat;
	wire         o_wb_ack;
	wire  [3:0]  s;
	int bad_count = 0, n_compared = 0, seed = 32'ha3c37e05;
	always #10 i_sys_clk = ~i_sys_clk;
	mstsel_top i_mstsel_top (.*, .i_read_req_zero(r[2]), .i_read_req_one(r[3]),
		.i_write_req_zero(r[0]), .i_write_req_one(r[1]), .o_read_strobe_zero_b(s[2]),
		.o_read_strobe_one_b(s[3]), .o_write_strobe_zero_b(s[0]), .o_write_strobe_one_b(s[1]));
	mstsel_mem_model i_mstsel_mem_model (.i_sys_clk(i_sys_clk), .i_strobe_b(s), .o_len(len));
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
		@(posedge i_sys_clk);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} <= {2'b11, w, a, d, m};
		do @(posedge i_sys_clk); while (o_wb_ack !== 1'b1);
		{i_wb_cyc, i_wb_stb} <= 2'b00;
	endtask
	task automatic acc(input int k, input int n);
		q.push_back(32'(2 * n + (k < 2) + t[k]));
		@(posedge i_sys_clk) r[k] <= 1'b1;
		repeat (n) @(posedge i_sys_clk);
		r[k] <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
	endtask
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge i_sys_clk)
		if (o_wb_ack === 1'b1 && !i_wb_we)
		begin
			ea = q.pop_front();
			`CMP(o_wb_dat, ea)
		end
	always @(i_mstsel_mem_model.done)
	begin
		eb = q.pop_front();
		`CMP(len, eb)
	end
	initial
	begin
		#50us;
		bad_count++;
		end_sim();
	end
	initial
	begin
		repeat (4) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		q.push_back(32'h0);
		wb(0, 8'h64, 0, 4'hf);
		for (int i = 0; i < 8; i++)
		begin
			t = 4'($random(seed));
			wb(1, 8'h64, {28'h0, t}, 4'h1);
			wb(1, 8'h60, 32'hf, 4'hf);
			wb(1, 8'h64, 32'h0, 4'he);
			q.push_back({28'h0, t});
			wb(0, 8'h64, 0, 4'hf);
			q.push_back(32'h0);
			wb(0, 8'h68, 0, 4'hf);
			for (int k = 0; k < 4; k++)
				acc(k, 1 + i % 3);
		end
		end_sim();
	end
endmodule
